// [bcs_sequencer.v]
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "bcs_defs.vh"
// What this block does
// - close by momentary coil pulse, open by momentary reverse pulse, no holding drive
// - contactor position kept on power loss or fault, no operation issued
// - remote open needs closed contactor and open command held beyond delay
// - remote open also needs supply-live low beyond its own delay
// - local open and close accepted only while bypass switch closed
// - auto open after supply-live low beyond hours delay
// - remote close needs open contactor and close command held beyond delay
// - auto close after supply-live high beyond its delay
module bcs_sequencer #(
    parameter MS_CYCLES = `BCS_MS_CYCLES,
    parameter HOUR_TENTHS = `BCS_HOUR_TENTHS
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [7:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrStrobe,
    input wire regRdStrobe,
    output reg [31:0] regRdData,
    input wire openCmd,
    input wire closeCmd,
    input wire supplyLive,
    input wire bypassClosed,
    input wire localOpen,
    input wire localClose,
    input wire contactorSense,
    output reg coilClose,
    output reg coilOpen,
    output reg contactorClosed,
    output wire coilBusy
);
    localparam ST_INIT = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_CLOSE = 2'h2;
    localparam ST_OPEN = 2'h3;

    reg [1:0] state;
    reg [7:0] pulseCnt;
    reg [5:0] openCmdDly;
    reg [5:0] deadShortDly;
    reg [5:0] closeCmdDly;
    reg [5:0] liveDly;
    reg [5:0] deadLongHrs;
    reg [7:0] pulseMs;
    reg localOpenQ;
    reg localCloseQ;
    reg initDone;
    // next values of the coil sequencer
    reg [1:0] next_state;
    reg [7:0] next_pulseCnt;
    reg next_coilClose;
    reg next_coilOpen;
    reg next_contactorClosed;

    wire msTick;
    wire tenthTick;
    wire hourTick;
    wire [3:0] shortCond;
    wire [23:0] shortLimit;
    wire [3:0] shortDone;
    wire deadLongDone;
    wire localOpenEdge;
    wire localCloseEdge;
    wire wantOpen;
    wire wantClose;
    wire remoteOpenReq;
    wire autoOpenReq;
    wire localOpenReq;
    wire remoteCloseReq;
    wire autoCloseReq;
    wire localCloseReq;
    wire pulseEnd;
    wire [31:0] statusWord;

    function [5:0] clampVal;
        input [31:0] v;
        input [5:0] lo;
        input [5:0] hi;
        begin
            if (v < {26'h0, lo})
                clampVal = lo;
            else if (v > {26'h0, hi})
                clampVal = hi;
            else
                clampVal = v[5:0];
        end
    endfunction

    bcs_prescale #(
        .MS_CYCLES(MS_CYCLES),
        .TENTH_MS(`BCS_TENTH_MS),
        .HOUR_TENTHS(HOUR_TENTHS)
    ) uPrescale (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .msTick(msTick),
        .tenthTick(tenthTick),
        .hourTick(hourTick)
    );

    // timer 0 open command, 1 supply dead short, 2 close command, 3 supply live
    assign shortCond = {supplyLive, closeCmd, ~supplyLive, openCmd};
    assign shortLimit = {liveDly, closeCmdDly, deadShortDly, openCmdDly};

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : gShort
            bcs_persist uTmr (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .tick(tenthTick),
                .cond(shortCond[i]),
                .limit(shortLimit[6*i+5:6*i]),
                .expired(shortDone[i])
            );
        end
    endgenerate

    bcs_persist uDeadLong (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tick(hourTick),
        .cond(~supplyLive),
        .limit(deadLongHrs),
        .expired(deadLongDone)
    );

    assign localOpenEdge = localOpen & ~localOpenQ;
    assign localCloseEdge = localClose & ~localCloseQ;

    // requests per source
    assign remoteOpenReq = shortDone[0] & shortDone[1];
    assign autoOpenReq = deadLongDone;
    assign localOpenReq = localOpenEdge & bypassClosed;
    assign remoteCloseReq = shortDone[2];
    assign autoCloseReq = shortDone[3];
    assign localCloseReq = localCloseEdge & bypassClosed;

    // a request only counts when it moves the contactor to the other side
    assign wantOpen = contactorClosed & (remoteOpenReq | autoOpenReq | localOpenReq);
    assign wantClose = ~contactorClosed & (remoteCloseReq | autoCloseReq | localCloseReq);

    assign coilBusy = (state == ST_CLOSE) || (state == ST_OPEN);

    // pulse ends on the ms tick that completes the set width
    assign pulseEnd = msTick && (pulseCnt + 8'h1 >= pulseMs);

    // status word from its bit positions
    assign statusWord[31:7] = 25'h0;
    assign statusWord[`BCS_ST_CLOSED] = contactorClosed;
    assign statusWord[`BCS_ST_BUSY] = coilBusy;
    assign statusWord[`BCS_ST_BYPASS] = bypassClosed;
    assign statusWord[`BCS_ST_LIVE] = supplyLive;
    assign statusWord[`BCS_ST_OPEN_CMD] = openCmd;
    assign statusWord[`BCS_ST_CLOSE_CMD] = closeCmd;
    assign statusWord[`BCS_ST_INIT_DONE] = initDone;

    // settings registers, clamped to their legal range
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            openCmdDly <= `BCS_OPEN_CMD_RST;
            deadShortDly <= `BCS_DEAD_SHORT_RST;
            closeCmdDly <= `BCS_CLOSE_CMD_RST;
            liveDly <= `BCS_LIVE_RST;
            deadLongHrs <= `BCS_DEAD_LONG_RST;
            pulseMs <= `BCS_PULSE_MS_RST;
        end
        else if (regWrStrobe)
        begin
            case (regAddr)
                `BCS_ADDR_OPEN_CMD_DLY:
                    openCmdDly <= clampVal(regWrData, `BCS_TENTH_MIN, `BCS_TENTH_MAX);
                `BCS_ADDR_DEAD_SHORT_DLY:
                    deadShortDly <= clampVal(regWrData, `BCS_TENTH_MIN, `BCS_TENTH_MAX);
                `BCS_ADDR_CLOSE_CMD_DLY:
                    closeCmdDly <= clampVal(regWrData, `BCS_TENTH_MIN, `BCS_TENTH_MAX);
                `BCS_ADDR_LIVE_DLY:
                    liveDly <= clampVal(regWrData, `BCS_TENTH_MIN, `BCS_TENTH_MAX);
                `BCS_ADDR_DEAD_LONG_HRS:
                    deadLongHrs <= clampVal(regWrData, `BCS_HRS_MIN, `BCS_HRS_MAX);
                `BCS_ADDR_PULSE_MS:
                    pulseMs <= (regWrData[7:0] < `BCS_PULSE_MIN) ? `BCS_PULSE_MIN :
                        regWrData[7:0];
                default:
                    pulseMs <= pulseMs;
            endcase
        end
    end

    // read data valid only in the cycle after the strobe
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            regRdData <= 32'h0;
        else if (regRdStrobe)
        begin
            case (regAddr)
                `BCS_ADDR_STATUS:
                    regRdData <= statusWord;
                `BCS_ADDR_OPEN_CMD_DLY:
                    regRdData <= {26'h0, openCmdDly};
                `BCS_ADDR_DEAD_SHORT_DLY:
                    regRdData <= {26'h0, deadShortDly};
                `BCS_ADDR_CLOSE_CMD_DLY:
                    regRdData <= {26'h0, closeCmdDly};
                `BCS_ADDR_LIVE_DLY:
                    regRdData <= {26'h0, liveDly};
                `BCS_ADDR_DEAD_LONG_HRS:
                    regRdData <= {26'h0, deadLongHrs};
                `BCS_ADDR_PULSE_MS:
                    regRdData <= {24'h0, pulseMs};
                default:
                    regRdData <= 32'h0;
            endcase
        end
        else
            regRdData <= 32'h0;
    end

    // coil sequencer, next values
    always @*
    begin
        next_state = state;
        next_pulseCnt = pulseCnt;
        next_coilClose = coilClose;
        next_coilOpen = coilOpen;
        next_contactorClosed = contactorClosed;
        case (state)
            ST_INIT:
            begin
                // adopt the sensed position, never drive the coil here
                next_contactorClosed = contactorSense;
                next_state = ST_IDLE;
            end
            ST_IDLE:
            begin
                next_pulseCnt = 8'h0;
                if (wantOpen)
                begin
                    next_coilOpen = 1'b1;
                    next_state = ST_OPEN;
                end
                else if (wantClose)
                begin
                    next_coilClose = 1'b1;
                    next_state = ST_CLOSE;
                end
            end
            ST_CLOSE, ST_OPEN:
            begin
                // new requests are not looked at until the pulse ends
                if (msTick)
                    next_pulseCnt = pulseCnt + 8'h1;
                if (pulseEnd)
                begin
                    next_coilClose = 1'b0;
                    next_coilOpen = 1'b0;
                    next_contactorClosed = (state == ST_CLOSE);
                    next_state = ST_IDLE;
                end
            end
            default:
                next_state = ST_INIT;
        endcase
    end

    // coil sequencer registers
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_INIT;
            pulseCnt <= 8'h0;
            coilClose <= 1'b0;
            coilOpen <= 1'b0;
            contactorClosed <= 1'b0;
            initDone <= 1'b0;
            localOpenQ <= 1'b0;
            localCloseQ <= 1'b0;
        end
        else
        begin
            state <= next_state;
            pulseCnt <= next_pulseCnt;
            coilClose <= next_coilClose;
            coilOpen <= next_coilOpen;
            contactorClosed <= next_contactorClosed;
            localOpenQ <= localOpen;
            localCloseQ <= localClose;
            if (state == ST_INIT)
                initDone <= 1'b1;
        end
    end
endmodule // bcs_sequencer

// [bcs_defs.vh]
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH

// clock and time base
`define BCS_CLK_PERIOD_NS 4
`define BCS_MS_NS 1000000
`define BCS_MS_CYCLES (`BCS_MS_NS / `BCS_CLK_PERIOD_NS)
`define BCS_TENTH_MS 100
`define BCS_HOUR_S 3600
`define BCS_HOUR_TENTHS (`BCS_HOUR_S * 10)

// register offsets (byte addresses)
`define BCS_ADDR_STATUS 8'h00
`define BCS_ADDR_OPEN_CMD_DLY 8'h04
`define BCS_ADDR_DEAD_SHORT_DLY 8'h08
`define BCS_ADDR_CLOSE_CMD_DLY 8'h0c
`define BCS_ADDR_LIVE_DLY 8'h10
`define BCS_ADDR_DEAD_LONG_HRS 8'h14
`define BCS_ADDR_PULSE_MS 8'h18

// reset values: delays in tenths of a second, hours, milliseconds
`define BCS_OPEN_CMD_RST 6'h0a
`define BCS_DEAD_SHORT_RST 6'h32
`define BCS_CLOSE_CMD_RST 6'h0a
`define BCS_LIVE_RST 6'h32
`define BCS_DEAD_LONG_RST 6'h06
`define BCS_PULSE_MS_RST 8'h64

// setting limits
`define BCS_TENTH_MIN 6'h02
`define BCS_TENTH_MAX 6'h32
`define BCS_HRS_MIN 6'h01
`define BCS_HRS_MAX 6'h10
`define BCS_PULSE_MIN 8'h01

// status bit positions
`define BCS_ST_CLOSED 0
`define BCS_ST_BUSY 1
`define BCS_ST_BYPASS 2
`define BCS_ST_LIVE 3
`define BCS_ST_OPEN_CMD 4
`define BCS_ST_CLOSE_CMD 5
`define BCS_ST_INIT_DONE 6

`endif

// [bcs_prescale.v]
`timescale 1ns/1ps
module bcs_prescale #(
    parameter MS_CYCLES = 250000,
    parameter TENTH_MS = 100,
    parameter HOUR_TENTHS = 36000
) (
    input wire clk_sys,
    input wire rst_b,
    output reg msTick,
    output reg tenthTick,
    output reg hourTick
);
    reg [31:0] cycCnt;
    reg [7:0] msCnt;
    reg [15:0] tenthCnt;

    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cycCnt <= 32'h0;
            msCnt <= 8'h0;
            tenthCnt <= 16'h0;
            msTick <= 1'b0;
            tenthTick <= 1'b0;
            hourTick <= 1'b0;
        end
        else
        begin
            msTick <= 1'b0;
            tenthTick <= 1'b0;
            hourTick <= 1'b0;
            if (cycCnt == MS_CYCLES - 1)
            begin
                cycCnt <= 32'h0;
                msTick <= 1'b1;
                if (msCnt == TENTH_MS - 1)
                begin
                    msCnt <= 8'h0;
                    tenthTick <= 1'b1;
                    if (tenthCnt == HOUR_TENTHS - 1)
                    begin
                        tenthCnt <= 16'h0;
                        hourTick <= 1'b1;
                    end
                    else
                        tenthCnt <= tenthCnt + 16'h1;
                end
                else
                    msCnt <= msCnt + 8'h1;
            end
            else
                cycCnt <= cycCnt + 32'h1;
        end
    end
endmodule // bcs_prescale

// [bcs_persist.v]
`timescale 1ns/1ps
module bcs_persist (
    input wire clk_sys,
    input wire rst_b,
    input wire tick,
    input wire cond,
    input wire [5:0] limit,
    output wire expired
);
    reg [5:0] cnt;

    // counts ticks while cond holds, restarts from zero once broken
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            cnt <= 6'h0;
        else if (!cond)
            cnt <= 6'h0;
        else if (tick && cnt != 6'h3f)
            cnt <= cnt + 6'h1;
    end

    // strictly longer than the setting
    assign expired = cond && (cnt > limit);
endmodule // bcs_persist

// [bcs_sequencer_chk.sv]
`timescale 1ns/1ps
module bcs_sequencer_chk #(
    parameter MS_CYCLES = 4,
    parameter HOUR_TENTHS = 3
) (
    input wire clk_sys,
    input wire rst_b,
    input wire coilClose,
    input wire coilOpen,
    input wire contactorClosed,
    input wire coilBusy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // edges since reset, saturating
    reg [1:0] upCnt;
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            upCnt <= 2'h0;
        else if (upCnt != 2'h3)
            upCnt <= upCnt + 2'h1;
    end
    AST_COIL_EXCL: assert property (!(coilOpen && coilClose))
        else $error("both coil drives on");
    // cycles the coil has been driven in one pulse, widest pulse is 255 ms
    localparam int ON_MAX = MS_CYCLES * 256;
    reg [31:0] onCnt;
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            onCnt <= 32'h0;
        else if (coilOpen || coilClose)
            onCnt <= onCnt + 32'h1;
        else
            onCnt <= 32'h0;
    end
    AST_COIL_SHORT: assert property (onCnt <= ON_MAX)
        else $error("coil held on");
    AST_OPEN_NEEDS_CLOSED: assert property ($rose(coilOpen) |-> contactorClosed)
        else $error("open pulse while open");
    AST_CLOSE_NEEDS_OPEN: assert property ($rose(coilClose) |-> !contactorClosed)
        else $error("close pulse while closed");
    AST_OPEN_RESULT: assert property ($fell(coilOpen) |-> !contactorClosed)
        else $error("state not open after pulse");
    AST_CLOSE_RESULT: assert property ($fell(coilClose) |-> contactorClosed)
        else $error("state not closed after pulse");
    AST_STATE_ONLY: assert property ($changed(contactorClosed) && upCnt == 2'h3
        |-> $fell(coilOpen) || $fell(coilClose)) else $error("state moved alone");
    AST_BUSY_COVERS: assert property (coilOpen || coilClose |-> coilBusy)
        else $error("coil on without busy");
    AST_NO_RETRIGGER: assert property ($rose(coilOpen || coilClose)
        |-> !$past(coilBusy)) else $error("pulse started while busy");
    COV_OPEN: cover property ($rose(coilOpen));
    COV_CLOSE: cover property ($rose(coilClose));
    COV_OPENED: cover property ($fell(contactorClosed));
endmodule // bcs_sequencer_chk

bind bcs_sequencer bcs_sequencer_chk #(.MS_CYCLES(MS_CYCLES), .HOUR_TENTHS(HOUR_TENTHS)) chk (.*);

// [bcs_outstation.sv]
`timescale 1ns/1ps
module bcs_outstation (
    input wire clk_sys,
    output reg openCmd,
    output reg closeCmd,
    output reg supplyLive
);
    initial
    begin
        openCmd = 1'b0;
        closeCmd = 1'b0;
        supplyLive = 1'b1;
    end
    // momentary command, released after n cycles
    task cmd(input bit isOpen, input int n);
    begin
        @(posedge clk_sys);
        if (isOpen)
            openCmd <= 1'b1;
        else
            closeCmd <= 1'b1;
        repeat (n) @(posedge clk_sys);
        openCmd <= 1'b0;
        closeCmd <= 1'b0;
    end
    endtask
    task live(input bit v);
    begin
        @(posedge clk_sys);
        supplyLive <= v;
    end
    endtask
endmodule // bcs_outstation

// [bcs_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
    reg clk_sys = 1'b0;
    reg rst_b = 1'b0;
    reg [7:0] regAddr = 8'h00;
    reg [31:0] regWrData = 32'h0;
    reg regWrStrobe = 1'b0;
    reg regRdStrobe = 1'b0;
    reg bypassClosed = 1'b0;
    reg localOpen = 1'b0;
    reg localClose = 1'b0;
    reg contactorSense = 1'b1;
    wire [31:0] regRdData;
    wire openCmd, closeCmd, supplyLive, coilClose, coilOpen, contactorClosed, coilBusy;
    int failures = 0;
    int check_count = 0;
    always #2 clk_sys = ~clk_sys;
    bcs_outstation ost (.clk_sys(clk_sys), .openCmd(openCmd), .closeCmd(closeCmd),
        .supplyLive(supplyLive));
    bcs_sequencer #(.MS_CYCLES(4), .HOUR_TENTHS(3)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData), .openCmd(openCmd),
        .closeCmd(closeCmd), .supplyLive(supplyLive), .bypassClosed(bypassClosed),
        .localOpen(localOpen), .localClose(localClose), .contactorSense(contactorSense),
        .coilClose(coilClose), .coilOpen(coilOpen), .contactorClosed(contactorClosed),
        .coilBusy(coilBusy));
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge clk_sys);
        regWrStrobe <= 1'b0;
    end
    endtask
    task rdchk(input [7:0] a, input [31:0] e);
    begin
        @(posedge clk_sys);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge clk_sys);
        regRdStrobe <= 1'b0;
        #1 `CHK("reg", e, regRdData)
    end
    endtask
    // watch n cycles for a coil pulse of one kind
    task op(input bit isOpen, input int n, output bit seen);
    begin
        seen = 1'b0;
        repeat (n)
        begin
            @(posedge clk_sys);
            #1 if ((isOpen ? coilOpen : coilClose) === 1'b1) seen = 1'b1;
        end
    end
    endtask
    task t_regs;
    begin
        `CHK("closed", 1'b1, contactorClosed)
        rdchk(8'h00, 32'h49);
        rdchk(8'h04, 32'ha);
        rdchk(8'h08, 32'h32);
        rdchk(8'h0c, 32'ha);
        rdchk(8'h10, 32'h32);
        rdchk(8'h14, 32'h6);
        rdchk(8'h1c, 32'h0);
        wr(8'h04, 32'h1);
        rdchk(8'h04, 32'h2);
        wr(8'h08, 32'h2);
        wr(8'h0c, 32'h2);
        wr(8'h10, 32'h2);
        wr(8'h14, 32'h10);
        rdchk(8'h18, 32'h64);
        wr(8'h18, 32'h0);
        rdchk(8'h18, 32'h1);
        rdchk(8'h14, 32'h10);
    end
    endtask
    task t_remote_open;
        bit s;
    begin
        fork ost.cmd(1'b1, 1600); op(1'b1, 1700, s); join
        `CHK("open live", 1'b0, s)
        ost.live(1'b0);
        repeat (1600) @(posedge clk_sys);
        fork
            begin ost.cmd(1'b1, 700); ost.cmd(1'b1, 700); end
            op(1'b1, 1500, s);
        join
        `CHK("open broken", 1'b0, s)
        fork ost.cmd(1'b1, 2000); op(1'b1, 2100, s); join
        `CHK("open remote", 1'b1, s)
        `CHK("closed", 1'b0, contactorClosed)
    end
    endtask
    task t_remote_close;
        bit s;
    begin
        @(posedge clk_sys);
        localClose <= 1'b1;
        op(1'b0, 20, s);
        @(posedge clk_sys);
        localClose <= 1'b0;
        `CHK("local no bypass", 1'b0, s)
        fork ost.cmd(1'b0, 2000); op(1'b0, 2100, s); join
        `CHK("close remote", 1'b1, s)
        `CHK("closed", 1'b1, contactorClosed)
    end
    endtask
    task t_local_open;
        bit s;
    begin
        @(posedge clk_sys);
        bypassClosed <= 1'b1;
        @(posedge clk_sys);
        localOpen <= 1'b1;
        op(1'b1, 20, s);
        @(posedge clk_sys);
        localOpen <= 1'b0;
        bypassClosed <= 1'b0;
        `CHK("local open", 1'b1, s)
        `CHK("closed", 1'b0, contactorClosed)
    end
    endtask
    task t_auto;
        bit s;
    begin
        ost.live(1'b1);
        op(1'b0, 2000, s);
        `CHK("auto close", 1'b1, s)
        wr(8'h14, 32'h1);
        ost.live(1'b0);
        op(1'b1, 1100, s);
        `CHK("auto open early", 1'b0, s)
        op(1'b1, 3000, s);
        `CHK("auto open", 1'b1, s)
        `CHK("closed", 1'b0, contactorClosed)
    end
    endtask
    // mid-run reset while open: position comes back from the sense strap
    task t_reset;
        bit s;
    begin
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK("coil in reset", 1'b0, coilOpen | coilClose)
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK("closed after reset", 1'b1, contactorClosed)
        rdchk(8'h14, 32'h6);
        op(1'b1, 20, s);
        `CHK("no pulse after reset", 1'b0, s)
    end
    endtask
    task finish_test;
    begin
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    initial
    begin
        #200000;
        failures++;
        finish_test;
    end
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_regs;
        t_remote_open;
        t_remote_close;
        t_local_open;
        t_auto;
        t_reset;
        finish_test;
    end
endmodule // tb
